// file: rtl/sample_fifo_readout.sv
// byte fifo for light and flicker samples with its register readout
// Notes on behaviour
// - light bytes enter if enabled and flicker is off, done or overridden.
// - with compression on, flicker samples are compressed before entering.
// - with delta on, only the change from the last flicker sample enters.
// - the width field N keeps flicker sample bits 0 through N.
// - the irq is high while the level exceeds twice the threshold.
// - the level counts bytes 0 to 512, bits 9:2 first status, 1:0 second.
// - a byte lost to a full fifo sets overflow until power-on or clear.
// - reading more than was stored sets underflow until power-on or clear.
// - each data read of a non-empty fifo advances the read pointer, and lowers the level unless a byte is stored in the same cycle.
// - a data read beyond the level returns zero and sets underflow.
`timescale 1ns/1ps
module sample_fifo_readout (
    input  wire logic                        ref_clk_i,   // 40 MHz clock
    input  wire logic                        rst_i,       // async reset
    input  wire logic                        power_on_enable_i, // low clears
    input  wire logic                        buffer_clear_i,    // clear pulse
    input  wire sample_fifo_pkg::reg_req_t   req_i,       // register access
    input  wire sample_fifo_pkg::sample_in_t smp_i,       // sample stream
    output logic [7:0]                       rdata_o,     // read data
    output logic                             buffer_irq_o // level irq
);
    logic [7:0] mem [sample_fifo_pkg::FIFO_DEPTH];
    sample_fifo_pkg::state_t s_reg, s_next;
    logic [sample_fifo_pkg::SAMPLE_W-1:0] smask, masked, coded;
    logic [7:0] push_byte;
    logic       push, pop, rd_data, full, empty, clr, light_ok;

    assign clr = buffer_clear_i | ~power_on_enable_i;
    assign full  = s_reg.level == 10'(sample_fifo_pkg::FIFO_DEPTH);
    assign empty = s_reg.level == '0;
    assign rd_data = req_i.rd && req_i.addr == sample_fifo_pkg::ADDR_DATA;
    assign pop = rd_data && !empty;

    assign light_ok = s_reg.cfg2[sample_fifo_pkg::BIT_WEN] &&
        (smp_i.flicker_off || smp_i.light_finish_after_flicker ||
         smp_i.light_sample_count >= smp_i.flicker_sample_count);

    always_comb begin
        smask  = 16'(17'h0_0002 << s_reg.cfg2[3:0]) - 16'h0001;
        masked = smp_i.flicker_sample & smask;
        coded = s_reg.cfg2[sample_fifo_pkg::BIT_DELTA] ?
            masked - s_reg.prev : masked;
        // compression keeps only the low byte of the coded sample
        if (s_reg.cfg2[sample_fifo_pkg::BIT_COMP] ||
            s_reg.cfg2[3:0] <= sample_fifo_pkg::COMP_BITS) begin
            push_byte = coded[7:0];
        end else begin
            push_byte = coded[15:8];
        end
        push = (smp_i.light_valid && light_ok) || smp_i.flicker_valid;
        if (smp_i.light_valid && light_ok) begin
            push_byte = smp_i.light_byte;
        end
    end

    always_comb begin
        s_next = s_reg;
        if (req_i.wr && req_i.addr == sample_fifo_pkg::ADDR_CFG2) begin
            s_next.cfg2 = req_i.wdata & sample_fifo_pkg::CFG2_WMASK;
        end
        if (req_i.wr && req_i.addr == sample_fifo_pkg::ADDR_THR) begin
            s_next.thr = req_i.wdata;
        end
        if (smp_i.flicker_valid && !(smp_i.light_valid && light_ok)) begin
            s_next.prev = masked;
        end
        if (push && !full) begin
            s_next.wptr = s_reg.wptr + 9'h001;
        end
        if (pop) begin
            s_next.rptr = s_reg.rptr + 9'h001;
        end
        s_next.level = s_reg.level + 10'(push && !full) - 10'(pop);
        // overflow set
        // a push meeting a full fifo is lost even if a read frees a byte
        // in the same cycle, so it must still raise the flag
        if (push && full) begin
            s_next.ovf = 1'b1;
        end
        if (rd_data && empty) begin
            s_next.udf = 1'b1;
        end
        s_next.rdata = 8'h00;
        if (req_i.rd) begin
            case (req_i.addr)
                sample_fifo_pkg::ADDR_CFG2: s_next.rdata = s_reg.cfg2;
                sample_fifo_pkg::ADDR_THR: s_next.rdata = s_reg.thr;
                sample_fifo_pkg::ADDR_STAT_HI: begin
                    s_next.rdata = s_reg.level[9:2];
                    s_next.snap_lo = {s_reg.ovf, s_reg.udf, 4'h0,
                                      s_reg.level[1:0]};
                end
                sample_fifo_pkg::ADDR_STAT_LO: s_next.rdata = s_reg.snap_lo;
                sample_fifo_pkg::ADDR_DATA:
                    s_next.rdata = empty ? 8'h00 : mem[s_reg.rptr];
                default: s_next.rdata = 8'h00;
            endcase
        end
        if (clr) begin
            s_next.wptr  = '0;
            s_next.rptr  = '0;
            s_next.level = '0;
            s_next.ovf   = 1'b0;
            s_next.udf   = 1'b0;
            s_next.snap_lo = '0;
            s_next.prev  = '0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg      <= '0;
            s_reg.cfg2 <= sample_fifo_pkg::CFG2_RESET;
            s_reg.thr  <= sample_fifo_pkg::THR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (push && !full && !clr) begin
            mem[s_reg.wptr] <= push_byte;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign buffer_irq_o = s_reg.level > {1'b0, s_reg.thr, 1'b0};

    // clear wins over a flag set in the same cycle, hence the !clr terms
    AST_OVF_STICKY: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        $past(s_reg.ovf) && !$past(clr) |-> s_reg.ovf)
        else $error("overflow dropped without clear");
    AST_OVF_SET: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        push && full && !clr |=> s_reg.ovf)
        else $error("overflow not set");
    AST_FULL_HOLD: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        full && !pop && !clr |=> full)
        else $error("full fifo changed without a read");
    AST_UDF_SET: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        rd_data && empty && !clr |=> s_reg.udf && rdata_o == 8'h00)
        else $error("empty read not flagged");
    AST_UDF_STICKY: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        s_reg.udf && !clr |=> s_reg.udf)
        else $error("underflow dropped without clear");
    AST_CLR_FLAGS: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        clr |=> s_reg.level == '0 && !s_reg.ovf && !s_reg.udf)
        else $error("clear left level or flags");
    AST_LVL_MAX: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        s_reg.level <= 10'(sample_fifo_pkg::FIFO_DEPTH))
        else $error("level beyond depth");
    AST_PTR_LVL: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        9'(s_reg.wptr - s_reg.rptr) == s_reg.level[8:0])
        else $error("pointers disagree with level");
    AST_PUSH_INC: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        push && !full && !pop && !clr |=>
        s_reg.level == $past(s_reg.level) + 10'h001)
        else $error("push did not raise level");
    AST_POP_DEC: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        pop && !push && !clr |=>
        s_reg.level == $past(s_reg.level) - 10'h001)
        else $error("read did not lower level");
    AST_RDATA_IDLE: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        !req_i.rd |=> rdata_o == 8'h00)
        else $error("read data stood past its cycle");
    AST_IRQ: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        s_reg.level == {1'b0, s_reg.thr, 1'b0} |-> !buffer_irq_o)
        else $error("irq at level equal threshold");
    AST_IRQ_ABOVE: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        s_reg.level == {1'b0, s_reg.thr, 1'b0} + 10'h001 |-> buffer_irq_o)
        else $error("irq missing above threshold");
    AST_SNAP: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        req_i.rd && req_i.addr == sample_fifo_pkg::ADDR_STAT_HI && !clr
        |=> s_reg.snap_lo[1:0] == $past(s_reg.level[1:0]))
        else $error("status snapshot wrong");
    AST_LIGHT_OFF: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        smp_i.light_valid && !s_reg.cfg2[sample_fifo_pkg::BIT_WEN]
        && !smp_i.flicker_valid |-> !push)
        else $error("light pushed while disabled");
    AST_LIGHT_ON: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        smp_i.light_valid && s_reg.cfg2[sample_fifo_pkg::BIT_WEN]
        && smp_i.flicker_off |-> push && push_byte == smp_i.light_byte)
        else $error("enabled light byte not pushed");
    AST_WIDTH: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        s_reg.cfg2[3:0] == 4'hA |-> masked[15:11] == 5'h00)
        else $error("width mask wrong");
    AST_WIDTH_MAX: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        s_reg.cfg2[3:0] == 4'hF |-> masked == smp_i.flicker_sample)
        else $error("full width mask wrong");
    AST_COMP_LOW: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        smp_i.flicker_valid && !smp_i.light_valid
        && s_reg.cfg2[sample_fifo_pkg::BIT_COMP]
        && !s_reg.cfg2[sample_fifo_pkg::BIT_DELTA]
        |-> push_byte == masked[7:0])
        else $error("compressed byte wrong");
    AST_DELTA: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        smp_i.flicker_valid && !smp_i.light_valid
        && s_reg.cfg2[sample_fifo_pkg::BIT_DELTA]
        && s_reg.cfg2[sample_fifo_pkg::BIT_COMP]
        |-> push_byte == 8'(masked - s_reg.prev))
        else $error("delta byte wrong");
    COV_FULL: cover property (@(posedge ref_clk_i) full);
    COV_OVF: cover property (@(posedge ref_clk_i) push && full);
    COV_UDF: cover property (@(posedge ref_clk_i) rd_data && empty);
    COV_IRQ: cover property (@(posedge ref_clk_i) buffer_irq_o);
    COV_DELTA: cover property (@(posedge ref_clk_i)
        smp_i.flicker_valid && s_reg.cfg2[sample_fifo_pkg::BIT_DELTA]);
endmodule : sample_fifo_readout

// file: pkg/sample_fifo_pkg.sv
// constants and carriers for the sample fifo readout block
package sample_fifo_pkg;
    localparam int          FIFO_DEPTH    = 512;
    localparam int          PTR_W         = 9;
    localparam int          LVL_W         = 10;
    localparam int          SAMPLE_W      = 16;
    localparam logic [7:0]  ADDR_CFG2     = 8'hFB;
    localparam logic [7:0]  ADDR_THR      = 8'hFC;
    localparam logic [7:0]  ADDR_STAT_HI  = 8'hFD;
    localparam logic [7:0]  ADDR_STAT_LO  = 8'hFE;
    localparam logic [7:0]  ADDR_DATA     = 8'hFF;
    localparam logic [7:0]  CFG2_RESET    = 8'h8F;
    localparam logic [7:0]  THR_RESET     = 8'h7F;
    localparam logic [7:0]  CFG2_WMASK    = 8'hBF;
    localparam int          BIT_WEN       = 7;
    localparam int          BIT_COMP      = 5;
    localparam int          BIT_DELTA     = 4;
    localparam int          BIT_OVF       = 7;
    localparam int          BIT_UDF       = 6;
    localparam logic [3:0]  COMP_BITS     = 4'h7;

    typedef struct packed {
        logic [7:0]       addr;
        logic             wr;
        logic             rd;
        logic [7:0]       wdata;
    } reg_req_t;

    typedef struct packed {
        logic                light_valid;
        logic [7:0]          light_byte;
        logic                flicker_valid;
        logic [SAMPLE_W-1:0] flicker_sample;
        logic                flicker_off;
        logic                light_finish_after_flicker;
        logic [7:0]          light_sample_count;
        logic [7:0]          flicker_sample_count;
    } sample_in_t;

    typedef struct packed {
        logic [7:0]          cfg2;
        logic [7:0]          thr;
        logic [PTR_W-1:0]    wptr;
        logic [PTR_W-1:0]    rptr;
        logic [LVL_W-1:0]    level;
        logic                ovf;
        logic                udf;
        logic [7:0]          snap_lo;
        logic [7:0]          rdata;
        logic [SAMPLE_W-1:0] prev;
    } state_t;
endpackage : sample_fifo_pkg

// file: tb/fifo_host_model.sv
// host side model issuing register accesses to the fifo block
`timescale 1ns/1ps
module fifo_host_model (
    input  wire logic                 ref_clk_i, // clock
    output sample_fifo_pkg::reg_req_t req_o      // register access
);
    logic [7:0] exp_q[$];
    initial req_o = '0;
    // a gap cycle between accesses keeps each edge single-driven
    task automatic acc(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge ref_clk_i);
        #1 req_o = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge ref_clk_i);
        #1 req_o = '0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(a, 1'b0, 8'h00);
    endtask : rd
    task automatic pop(input logic [7:0] e);
        rd(sample_fifo_pkg::ADDR_DATA, e);
    endtask : pop
    task automatic status(input logic [9:0] l, input logic [1:0] f);
        rd(sample_fifo_pkg::ADDR_STAT_HI, l[9:2]);
        rd(sample_fifo_pkg::ADDR_STAT_LO, {f, 4'h0, l[1:0]});
    endtask : status
endmodule : fifo_host_model

// file: tb/sample_fifo_readout_test.sv
// self-checking bench for the sample fifo readout block
`timescale 1ns/1ps
module sample_fifo_readout_test;
    logic                        clk = 1'b0;
    logic                        rst = 1'b1;
    logic                        power_on_enable = 1'b1;
    logic                        clr = 1'b0;
    sample_fifo_pkg::reg_req_t   req;
    sample_fifo_pkg::sample_in_t smp = '0;
    logic [7:0]                  rdata;
    logic                        irq;
    logic                        seen = 1'b0;
    logic [4:0]                  t;
    logic [4:0]                  r1_case [5] =
        '{5'b01000, 5'b10000, 5'b10011, 5'b10101, 5'b11001};
    logic [7:0]                  b;
    logic [7:0]                  q[$];
    int                          fail_count = 0;
    int                          checked = 0;
    always #12.5 clk = ~clk;
    sample_fifo_readout i_dut (.ref_clk_i(clk), .rst_i(rst),
        .power_on_enable_i(power_on_enable), .buffer_clear_i(clr), .req_i(req),
        .smp_i(smp), .rdata_o(rdata), .buffer_irq_o(irq));
    fifo_host_model i_host (.ref_clk_i(clk), .req_o(req));
    task automatic bad(input logic [7:0] g, input logic [7:0] x);
        checked++;
        if (g !== x) begin
            fail_count++;
            $display("Error %0t got %h expected %h", $time, g, x);
        end
    endtask : bad
    task automatic cmp_irq(input logic x);
        bad({7'h0, irq}, {7'h0, x});
    endtask : cmp_irq
    always @(posedge clk) begin
        if (seen === 1'b1) bad(rdata, i_host.exp_q.pop_front());
        seen <= req.rd;
    end
    task automatic push(input logic lv, input logic [15:0] f);
        @(posedge clk);
        #1 smp.light_valid = lv;
        smp.flicker_valid = !lv;
        smp.light_byte = f[7:0];
        smp.flicker_sample = f;
        @(posedge clk);
        #1 smp.light_valid = 1'b0;
        smp.flicker_valid = 1'b0;
    endtask : push
    task automatic results();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        #1_000_000 fail_count++;
        results();
    end
    initial begin
        void'($urandom(32'h76f5_07ff));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        i_host.rd(sample_fifo_pkg::ADDR_CFG2, 8'h8f);
        i_host.rd(sample_fifo_pkg::ADDR_THR, 8'h7f);
        i_host.status(10'h000, 2'b00);
        i_host.wr(sample_fifo_pkg::ADDR_CFG2, 8'hff);
        i_host.wr(sample_fifo_pkg::ADDR_STAT_HI, 8'h55);
        i_host.rd(sample_fifo_pkg::ADDR_CFG2, 8'hbf);
        // cases as {enable, off, finish, count ok, stored}
        foreach (r1_case[i]) begin
            t = r1_case[i];
            i_host.wr(sample_fifo_pkg::ADDR_CFG2, {t[4], 7'h0f});
            smp.flicker_off = t[3];
            smp.light_finish_after_flicker = t[2];
            smp.light_sample_count = t[1] ? 8'h02 : 8'h01;
            smp.flicker_sample_count = 8'h02;
            b = 8'($urandom);
            push(1'b1, {8'h00, b});
            if (t[0]) q.push_back(b);
        end
        i_host.status(10'h003, 2'b00);
        cmp_irq(1'b0);
        i_host.wr(sample_fifo_pkg::ADDR_THR, 8'h01);
        cmp_irq(1'b1);
        i_host.pop(q.pop_front());
        cmp_irq(1'b0);
        while (q.size() > 0) i_host.pop(q.pop_front());
        i_host.status(10'h000, 2'b00);
        i_host.pop(8'h00);
        push(1'b1, 16'h0055);
        i_host.status(10'h001, 2'b01);
        @(posedge clk);
        #1 clr = 1'b1;
        @(posedge clk);
        #1 clr = 1'b0;
        i_host.status(10'h000, 2'b00);
        for (int w = 0; w < 8; w++) begin
            i_host.wr(sample_fifo_pkg::ADDR_CFG2, {4'h8, 4'(w)});
            push(1'b0, 16'hffff);
            i_host.pop(8'((16'h0002 << w) - 16'h0001));
        end
        // above a byte the high byte is kept unless compressed
        i_host.wr(sample_fifo_pkg::ADDR_CFG2, 8'h8a);
        push(1'b0, 16'hffff);
        i_host.pop(8'h07);
        i_host.wr(sample_fifo_pkg::ADDR_CFG2, 8'haf);
        push(1'b0, 16'h1234);
        i_host.pop(8'h34);
        i_host.wr(sample_fifo_pkg::ADDR_CFG2, 8'hbf);
        b = 8'($urandom);
        push(1'b0, 16'h1234 + 16'(b));
        i_host.pop(b);
        i_host.wr(sample_fifo_pkg::ADDR_CFG2, 8'h8f);
        repeat (513) push(1'b1, 16'($urandom));
        i_host.status(10'h200, 2'b10);
        cmp_irq(1'b1);
        @(posedge clk);
        #1 power_on_enable = 1'b0;
        @(posedge clk);
        #1 power_on_enable = 1'b1;
        i_host.status(10'h000, 2'b00);
        results();
    end
endmodule : sample_fifo_readout_test
